//--- rtl/bli_exec.sv
// Execute stage for AND-with-file, bit clear, bit set and bit test with skip
`timescale 1ns/1ns
`default_nettype none
module bli_exec
    import bli_pkg::*;
(
    input wire logic core_clk_i,                // Instruction clock
    input wire logic reset_n_i,                 // Async reset, low
    input wire logic instr_valid_i,             // Opcode present this cycle
    input wire logic [OPC_W-1:0] opcode_i,      // Current opcode
    input wire logic [DATA_W-1:0] file_rdata_i, // Addressed file register value
    output logic [ADDR_W-1:0] file_addr_o,      // Address of file register
    output logic [DATA_W-1:0] file_wdata_o,     // Write data
    output logic file_we_o,                     // File write pulse
    output logic [DATA_W-1:0] work_o,           // Working register
    output logic zero_we_o,                     // Zero flag write pulse
    output logic zero_o,                        // Zero flag value to write
    output logic skip_o,                        // Prefetched opcode cancelled
    output logic nop_cycle_o                    // This cycle ran as no-op
);
    // ==========================================
    // Decode helpers
    // Classify the opcode; used by the decode and the checks
    function automatic bli_op_t decode_op(input logic [OPC_W-1:0] op);
        decode_op = BLI_NONE;
        if (op[11:6] == OP_AND_WORK_WITH_FILE) begin
            decode_op = BLI_AND;
        end else if (op[11:8] == OP_BIT_CLEAR_FILE) begin
            decode_op = BLI_BCLR;
        end else if (op[11:8] == OP_BIT_SET_FILE) begin
            decode_op = BLI_BSET;
        end else if (op[11:8] == OP_BIT_TEST_SKIP_IF_SET) begin
            decode_op = BLI_BTEST;
        end
    endfunction : decode_op

    // ==========================================
    // State
    logic [DATA_W-1:0] work_q, work_d;           // Working register
    logic [ADDR_W-1:0] addr_q, addr_d;           // Registered address
    logic [DATA_W-1:0] wdata_q, wdata_d;         // Registered write data
    logic fwe_q, fwe_d;                          // File write strobe
    logic zwe_q, zwe_d;                          // Zero write strobe
    logic zero_q, zero_d;                        // Zero value
    logic skip_q, skip_d;                        // Cancel next opcode
    logic nop_q, nop_d;                          // No-op marker

    // Fields of the current opcode
    bli_op_t op_cls;                             // Class of opcode
    logic [ADDR_W-1:0] faddr;                    // File address 0-31
    logic [2:0] bidx;                            // Bit index 0-7
    logic dest;                                  // Destination select
    logic [DATA_W-1:0] and_res;                  // AND result
    logic [DATA_W-1:0] bmask;                    // One-hot bit mask

    // ==========================================
    // Next-state logic
    // File address is decoded from the opcode for internal use only; the register file
    // sees just the registered address on file_addr_o, which follows for write.
    always_comb begin
        faddr = opcode_i[FADDR_MSB:FADDR_LSB];
        bidx = opcode_i[BIT_MSB:BIT_LSB];
        dest = opcode_i[DEST_POS];
        op_cls = decode_op(opcode_i);
        and_res = work_q & file_rdata_i;
        bmask = 8'h01 << bidx;
        work_d = work_q;
        addr_d = faddr;
        wdata_d = wdata_q;
        fwe_d = 1'b0;
        zwe_d = 1'b0;
        zero_d = zero_q;
        skip_d = 1'b0;
        nop_d = 1'b0;
        if (skip_q) begin
            // Prefetched opcode discarded, this cycle is a no-op
            // Dropped whether or not it was marked valid: the fetch side
            // cannot take back an opcode it has already handed over
            nop_d = 1'b1;
        end else if (instr_valid_i) begin
            case (op_cls)
                BLI_AND: begin
                    zwe_d = 1'b1;
                    zero_d = (and_res == 8'h00);
                    if (dest) begin
                        fwe_d = 1'b1;
                        wdata_d = and_res;
                    end else begin
                        work_d = and_res;
                    end
                end
                BLI_BCLR: begin
                    fwe_d = 1'b1;
                    wdata_d = file_rdata_i & ~bmask;
                end
                BLI_BSET: begin
                    fwe_d = 1'b1;
                    wdata_d = file_rdata_i | bmask;
                end
                BLI_BTEST: begin
                    skip_d = file_rdata_i[bidx];
                end
                default: begin
                    // Other opcodes belong to other units
                end
            endcase
        end
    end

    // Register update
    // Reset branch loads constants only, so no data path feeds the reset
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            work_q <= WORK_RST;
            addr_q <= ADDR_RST;
            wdata_q <= WDATA_RST;
            fwe_q <= 1'b0;
            zwe_q <= 1'b0;
            zero_q <= ZERO_RST;
            skip_q <= 1'b0;
            nop_q <= 1'b0;
        end else begin
            work_q <= work_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            fwe_q <= fwe_d;
            zwe_q <= zwe_d;
            zero_q <= zero_d;
            skip_q <= skip_d;
            nop_q <= nop_d;
        end
    end

    // ==========================================
    // Outputs, all from flip-flops
    // Plain copies of the flops, so consumers never see decode glitches
    assign file_addr_o = addr_q;
    assign file_wdata_o = wdata_q;
    assign file_we_o = fwe_q;
    assign work_o = work_q;
    assign zero_we_o = zwe_q;
    assign zero_o = zero_q;
    assign skip_o = skip_q;
    assign nop_cycle_o = nop_q;

    // ==========================================
    // Checks
    // All checks sleep while reset is low; after release the |=> checks only arm on the first edge,
    // but a_nop_cause and a_addr_field read $past in a consequent there, from an edge inside reset
    // Zero flag follows the AND result; the strobe marks the update
    a_and_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_AND)
        |=> (zero_we_o && zero_o == ($past(work_q & file_rdata_i) == 8'h00)))
        else $error("and did not update zero");
    // Destination zero lands in the working register, no file write
    a_and_to_work: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_AND && !opcode_i[5])
        |=> (!file_we_o && work_o == $past(work_q & file_rdata_i)))
        else $error("and to work wrong");
    // Destination one goes back to the file, working register kept
    a_and_to_file: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_AND && opcode_i[5])
        |=> (file_we_o && $stable(work_o) && file_wdata_o == $past(work_q & file_rdata_i)))
        else $error("and to file wrong");
    // Only the selected bit drops; the other seven pass through
    a_bit_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_BCLR)
        |=> (file_we_o && !zero_we_o
             && file_wdata_o == ($past(file_rdata_i) & ~(8'h01 << $past(opcode_i[7:5])))
             && file_addr_o == $past(opcode_i[4:0])))
        else $error("bit clear wrong");
    // Only the selected bit rises; flags untouched
    a_bit_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_BSET)
        |=> (file_we_o && !zero_we_o && file_wdata_o == ($past(file_rdata_i)
             | (8'h01 << $past(opcode_i[7:5])))))
        else $error("bit set wrong");
    // Skip raised exactly when the tested bit reads one
    a_test_skip: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_BTEST)
        |=> (skip_o == $past(file_rdata_i[opcode_i[7:5]]) && !file_we_o && !zero_we_o))
        else $error("bit test skip wrong");
    // The opcode behind a taken test must leave no trace
    a_skip_cancel: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        skip_o |=> (nop_cycle_o && !file_we_o && !zero_we_o && !skip_o && $stable(work_o)))
        else $error("prefetched opcode not cancelled");
    // A no-op cycle only ever follows a taken skip
    a_nop_cause: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        nop_cycle_o |-> $past(skip_o))
        else $error("no-op without skip");
    // A taken test spends two cycles: skip, then the no-op
    a_skip_two: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (instr_valid_i && !skip_q && decode_op(opcode_i) == BLI_BTEST
         && file_rdata_i[opcode_i[BIT_MSB:BIT_LSB]])
        |=> skip_o ##1 nop_cycle_o)
        else $error("taken test not two cycles");
    // Idle or foreign cycles must not touch file, flag or skip
    a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (!skip_q && (!instr_valid_i || decode_op(opcode_i) == BLI_NONE))
        |=> (!file_we_o && !zero_we_o && !skip_o && !nop_cycle_o && $stable(work_o)))
        else $error("idle cycle changed state");
    // Write address is the field of the opcode taken one edge before
    a_addr_field: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        file_we_o |-> file_addr_o == $past(opcode_i[FADDR_MSB:FADDR_LSB]))
        else $error("write address not from opcode field");
    // Bit instructions and the skip path leave the working register alone
    a_work_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (skip_q || decode_op(opcode_i) inside {BLI_BCLR, BLI_BSET, BLI_BTEST})
        |=> ($stable(work_o) && !zero_we_o))
        else $error("working register disturbed");
endmodule : bli_exec
`default_nettype wire

//--- rtl/bli_pkg.sv
// Package: constants for the bit and logic instruction executor
package bli_pkg;
    // ==========================================
    // Opcode fields
    localparam int OPC_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int FADDR_LSB = 0;
    localparam int FADDR_MSB = 4;
    localparam int DEST_POS = 5;
    localparam int BIT_LSB = 5;
    localparam int BIT_MSB = 7;
    // ==========================================
    // Opcode patterns (upper bits)
    localparam logic [5:0] OP_AND_WORK_WITH_FILE = 6'h05; // 0001 01
    localparam logic [3:0] OP_BIT_CLEAR_FILE = 4'h4;      // 0100
    localparam logic [3:0] OP_BIT_SET_FILE = 4'h5;        // 0101
    localparam logic [3:0] OP_BIT_TEST_SKIP_IF_SET = 4'h7; // 0111
    // ==========================================
    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [11:0] OPC_RST = 12'h000;
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam logic [7:0] WDATA_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    // ==========================================
    // Instruction classes
    typedef enum logic [2:0] {
        BLI_NONE,
        BLI_AND,
        BLI_BCLR,
        BLI_BSET,
        BLI_BTEST
    } bli_op_t;
endpackage : bli_pkg

//--- verification/bli_exec_tb_top.sv
// Self-checking bench for the bit and logic instruction executor
`timescale 1ns/1ns
`default_nettype none
module bli_exec_tb_top;
    import bli_pkg::*;
    // ==========================================
    // Stimulus, observed outputs and bookkeeping
    logic core_clk_i = 1'b0; // 100 MHz instruction clock
    logic reset_n_i = 1'b0; // Held low for five cycles
    logic instr_valid_i = 1'b0;
    logic [OPC_W-1:0] opcode_i = OPC_RST;
    logic [DATA_W-1:0] file_rdata_i = 8'h00;
    logic [ADDR_W-1:0] file_addr_o;
    logic [DATA_W-1:0] file_wdata_o, work_o;
    logic file_we_o, zero_we_o, zero_o, skip_o, nop_cycle_o;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0; // Hang guard
    logic [31:0] rng = 32'h28AC; // Xorshift state
    // Model state: expected outputs for the coming cycle
    logic [7:0] m_work = WORK_RST, m_wdata = 8'h00;
    logic [4:0] m_addr = 5'h00;
    logic m_zero = 1'b0, m_zwe = 1'b0, m_fwe = 1'b0, m_skip = 1'b0, m_nop = 1'b0;

    bli_exec bli_exec_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .instr_valid_i(instr_valid_i), .opcode_i(opcode_i), .file_rdata_i(file_rdata_i),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
        .work_o(work_o), .zero_we_o(zero_we_o), .zero_o(zero_o), .skip_o(skip_o),
        .nop_cycle_o(nop_cycle_o));

    // ==========================================
    // Clock and hang guard
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin // Run needs about 2410 cycles
            bad_count++;
            test_done();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // One comparison; prints its own mismatch line
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Model of one taken edge, from the opcode now driven
    task automatic step();
        logic [7:0] r;
        logic s;
        int b;
        b = opcode_i[7:5];
        r = m_work & file_rdata_i;
        s = m_skip;
        {m_fwe, m_zwe, m_nop, m_skip} = 4'h0;
        m_addr = opcode_i[4:0];
        if (!reset_n_i) begin
            // Reset held across the edge: every output at its reset value
            m_work = WORK_RST;
            m_wdata = WDATA_RST;
            m_addr = ADDR_RST;
            m_zero = ZERO_RST;
        end else if (s) begin
            m_nop = 1'b1; // Prefetched opcode dropped, valid or not
        end else if (instr_valid_i) begin
            if (opcode_i[11:6] == OP_AND_WORK_WITH_FILE) begin
                m_zwe = 1'b1;
                m_zero = (r == 8'h00);
                if (opcode_i[5]) begin
                    m_fwe = 1'b1;
                    m_wdata = r;
                end else begin
                    m_work = r;
                end
            end else if (opcode_i[11:8] == OP_BIT_CLEAR_FILE) begin
                m_fwe = 1'b1;
                m_wdata = file_rdata_i & ~(8'h01 << b);
            end else if (opcode_i[11:8] == OP_BIT_SET_FILE) begin
                m_fwe = 1'b1;
                m_wdata = file_rdata_i | (8'h01 << b);
            end else if (opcode_i[11:8] == OP_BIT_TEST_SKIP_IF_SET) begin
                m_skip = file_rdata_i[b];
            end
        end
    endtask : step

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // ==========================================
    // Main sequence: random mix of listed and unknown opcodes, back to back
    initial begin
        repeat (5) @(posedge core_clk_i);
        #1 reset_n_i = 1'b1;
        for (int i = 0; i < 2400; i++) begin
            @(posedge core_clk_i);
            #1;
            chk(8'(file_we_o), 8'(m_fwe), "file write");
            chk(8'(zero_we_o), 8'(m_zwe), "zero write");
            chk(8'(zero_o), 8'(m_zero), "zero value");
            chk(work_o, m_work, "work");
            chk(8'(skip_o), 8'(m_skip), "skip");
            chk(8'(nop_cycle_o), 8'(m_nop), "no-op");
            if (m_fwe || !reset_n_i) chk(8'(file_addr_o), 8'(m_addr), "address");
            if (m_fwe || !reset_n_i) chk(file_wdata_o, m_wdata, "write data");
            rng = xs(rng);
            // Always present an opcode after a taken test, so the drop is seen
            instr_valid_i = m_skip | (rng[9:8] != 2'h0);
            case (rng[2:0])
                3'h0, 3'h1: opcode_i = {OP_AND_WORK_WITH_FILE, rng[15:10]};
                3'h2: opcode_i = {OP_BIT_CLEAR_FILE, rng[17:10]};
                3'h3: opcode_i = {OP_BIT_SET_FILE, rng[17:10]};
                3'h4, 3'h5: opcode_i = {OP_BIT_TEST_SKIP_IF_SET, rng[17:10]};
                3'h6: opcode_i = {4'hF, rng[17:10]}; // Not ours: ignored
                default: opcode_i = {6'h07, rng[15:10]}; // Neighbour of the AND code
            endcase
            file_rdata_i = rng[31:24];
            // Mid-run reset with traffic still running; reset must win
            if (i == 1200) reset_n_i = 1'b0;
            if (i == 1203) reset_n_i = 1'b1;
            step();
        end
        test_done();
    end
endmodule : bli_exec_tb_top
`default_nettype wire
